/* File: core/gpp_port.v */
// Eight-pin general-purpose port with analog disable, behind AXI4-Lite
//
// Functional notes
// RULE1 - Register bit n controls pin n, bit7 highest, bit0 lowest.
// RULE2 - Direction bit 1 makes the pin an output port.
// RULE3 - Output port pins drive the stored latch value.
// RULE4 - Latch writes are stored and appear directly on output pins.
// RULE5 - Data reads on output pins return the latch, not the pin.
// RULE6 - Direction bit 0 makes the pin an input port.
// RULE7 - On input pins a latch write only updates the latch.
// RULE8 - Input pins: ordinary read gives pin level, RMW read gives latch.
// RULE9 - Peripheral output enable hands the pin to the peripheral output.
// RULE10 - Peripheral-driven pins: ordinary read pin level, RMW read latch.
// RULE11 - Software disables sharing peripheral outputs before port use.
// RULE12 - Analog-disable 0 blocks digital input on analog pins; 1 enables.
// RULE13 - Peripheral digital input on analog pin needs disable 1, dir 0.
// RULE14 - Analog use needs dir 0, disable 0, peripheral off, pull-up 0; analog_enable here follows only the disable bit.
// RULE15 - Reset clears all direction bits, making every pin an input.
// RULE16 - Reset clears analog-disable bits, blocking digital input.
// RULE17 - Standby high-Z bit set in stop or watch floats every pin.
// RULE18 - In forced standby each internal input is held low and blocked.
// RULE19 - Serial clock and data-in inputs stay live if both wake enables.
// RULE20 - Standby high-Z bit clear keeps pin states and output levels.
// RULE21 - Pull-up bit 1 connects the pull-up, 0 disconnects it.
// RULE22 - Pull-up is disconnected whenever the pin is driven low.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`include "gpp_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module gpp_port #(
  parameter integer NPINS = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite slave
  input  wire [11:0]       s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [11:0]       s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Read-modify-write qualifier, sampled with the read address
  input  wire              rmw_read,
  // Pins
  input  wire [NPINS-1:0]  pin_in,
  output reg  [NPINS-1:0]  pin_out,
  output reg  [NPINS-1:0]  pin_oe,
  output reg  [NPINS-1:0]  pin_pullup,
  // Shared peripherals
  input  wire [NPINS-1:0]  periph_oe,
  input  wire [NPINS-1:0]  periph_out,
  output reg  [NPINS-1:0]  periph_in,
  output reg  [3:0]        analog_enable
);

  // ========================================================================
  // Registers
  reg [NPINS-1:0] port_output_latch;
  reg [NPINS-1:0] port_direction;
  reg [NPINS-1:0] port_pullup_enable;
  reg [3:0]       analog_input_disable_upper;
  reg [2:0]       standby_control;
  reg [1:0]       wake_control;

  reg [11:0] aw_addr;
  reg        aw_held;
  reg [31:0] w_data;
  reg        w_held;
  reg [3:0]  w_strb;

  // ========================================================================
  // Pin side combinational view
  wire standby_mode = standby_control[`GPP_STBY_STOP_BIT] |
                      standby_control[`GPP_STBY_WATCH_BIT];
  wire force_hiz = standby_control[`GPP_STBY_HIZ_BIT] & standby_mode;
  wire wake_live = wake_control[`GPP_WAKE_EIC_BIT] &
                   wake_control[`GPP_WAKE_SEL_BIT];

  reg [NPINS-1:0] next_oe;
  reg [NPINS-1:0] next_out;
  reg [NPINS-1:0] next_in;
  reg [NPINS-1:0] next_pull;
  integer i;

  always @* begin
    for (i = 0; i < NPINS; i = i + 1) begin
      // Peripheral has priority over the port latch
      if (periph_oe[i]) begin                             // see RULE9
        next_oe[i]  = 1'b1;
        next_out[i] = periph_out[i];
      end else begin
        next_oe[i]  = port_direction[i];                  // see RULE2 RULE6
        next_out[i] = port_output_latch[i];               // see RULE3 RULE7
      end
      if (force_hiz) begin
        next_oe[i] = 1'b0;                                // see RULE17
      end
      // Digital input path; analog pins gated by their disable bit
      next_in[i] = pin_in[i];
      if (i < `GPP_ANALOG_PINS && !analog_input_disable_upper[i % 4]) begin
        next_in[i] = 1'b0;                                // see RULE12
      end
      if (force_hiz && !(wake_live &&
          (i == `GPP_PIN_SCK || i == `GPP_PIN_SIN))) begin
        next_in[i] = 1'b0;                                // see RULE18 RULE19
      end
      // Pull-up only while not actively pulled low
      next_pull[i] = port_pullup_enable[i] &
                     !(next_oe[i] && !next_out[i]);       // see RULE21 RULE22
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe        <= {NPINS{1'b0}};
      pin_out       <= {NPINS{1'b0}};
      pin_pullup    <= {NPINS{1'b0}};
      periph_in     <= {NPINS{1'b0}};
      analog_enable <= 4'h0;
    end else begin
      // With the high-Z bit clear, standby changes nothing here
      pin_oe        <= next_oe;                           // see RULE20
      pin_out       <= next_out;                          // see RULE1
      pin_pullup    <= next_pull;
      periph_in     <= next_in;
      analog_enable <= ~analog_input_disable_upper;       // see RULE14
    end
  end

  // ========================================================================
  // AXI4-Lite write path
  function [7:0] merge8;
    input [7:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge8 = strb[0] ? data[7:0] : old;
    end
  endfunction

  wire do_write = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPP_RESP_OKAY;
      port_output_latch <= `GPP_RST_LATCH;
      port_direction <= `GPP_RST_DIR;                     // see RULE15
      port_pullup_enable <= `GPP_RST_PULLUP;
      analog_input_disable_upper <= `GPP_RST_AIDIS;       // see RULE16
      standby_control <= 3'b000;
      wake_control <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `GPP_RESP_OKAY;
        case (aw_addr)
          `GPP_OFS_LATCH:
            port_output_latch <= merge8(port_output_latch, w_data,
                                        w_strb);          // see RULE4
          `GPP_OFS_DIR:
            port_direction <= merge8(port_direction, w_data, w_strb);
          `GPP_OFS_PULLUP:
            port_pullup_enable <= merge8(port_pullup_enable, w_data,
                                         w_strb);
          `GPP_OFS_AIDIS:
            if (w_strb[0]) analog_input_disable_upper <= w_data[3:0];
          `GPP_OFS_STBY:
            if (w_strb[0]) standby_control <= w_data[2:0];
          `GPP_OFS_WAKE:
            if (w_strb[0]) wake_control <= w_data[1:0];
          default:
            s_axi_bresp <= `GPP_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read path
  // Input pins return the pin unless RMW; peripheral-driven pins likewise
  wire [NPINS-1:0] data_view =
    rmw_read ? port_output_latch :                        // see RULE8 RULE10
    ((port_direction & ~periph_oe & port_output_latch) |  // see RULE5
     (~(port_direction & ~periph_oe) & pin_in));

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `GPP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `GPP_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          `GPP_OFS_LATCH:  s_axi_rdata[7:0] <= data_view;
          `GPP_OFS_DIR:    s_axi_rdata[7:0] <= port_direction;
          `GPP_OFS_PULLUP: s_axi_rdata[7:0] <= port_pullup_enable;
          `GPP_OFS_AIDIS:  s_axi_rdata[3:0] <= analog_input_disable_upper;
          `GPP_OFS_STBY:   s_axi_rdata[2:0] <= standby_control;
          `GPP_OFS_WAKE:   s_axi_rdata[1:0] <= wake_control;
          default:         s_axi_rresp <= `GPP_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // gpp_port

`default_nettype wire

/* File: pkg/gpp_defines.vh */
// Register map, field positions, reset values and pin indices of the port
`ifndef GPP_DEFINES_VH
`define GPP_DEFINES_VH

// ==========================================================================
// Register byte offsets
`define GPP_OFS_LATCH      12'h000
`define GPP_OFS_DIR        12'h004
`define GPP_OFS_PULLUP     12'h008
`define GPP_OFS_AIDIS      12'h00C
`define GPP_OFS_STBY       12'h010
`define GPP_OFS_WAKE       12'h014

// ==========================================================================
// Reset values
`define GPP_RST_LATCH      8'h00
`define GPP_RST_DIR        8'h00
`define GPP_RST_PULLUP     8'h00
`define GPP_RST_AIDIS      4'h0

// ==========================================================================
// Field positions
`define GPP_STBY_HIZ_BIT   0
`define GPP_STBY_STOP_BIT  1
`define GPP_STBY_WATCH_BIT 2
`define GPP_WAKE_EIC_BIT   0
`define GPP_WAKE_SEL_BIT   1
`define GPP_ANALOG_PINS    4
`define GPP_PIN_SCK        5
`define GPP_PIN_SIN        7

// ==========================================================================
// AXI responses
`define GPP_RESP_OKAY      2'b00
`define GPP_RESP_SLVERR    2'b10

`endif

/* File: tb/gpp_pins_model.sv */
// Board-side pin model: port drive, external drivers, pull-ups
`timescale 1ns/100ps
`default_nettype none
module gpp_pins_model (
  input  wire logic       aclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output wire logic [7:0] pin_in
);
  // ==================
  // Wire level
  // A floating pin toggles, so a stale level never passes for a real one
  logic [7:0] flt = 8'h00;
  always @(posedge aclk) flt <= ~flt;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pin_pullup | flt));
endmodule // gpp_pins_model
`default_nettype wire

/* File: tb/gpp_port_assertions.sv */
// Concurrent checks on the port's bus answers and pin outputs
`timescale 1ns/100ps
`default_nettype none
module gpp_port_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pin_pullup,
  input wire logic [7:0]  periph_oe,
  input wire logic [7:0]  periph_out,
  input wire logic [7:0]  periph_in,
  input wire logic [3:0]  analog_enable
);
  // ==================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped before taken");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before taken");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  a_resp_single: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response repeated");
  a_reset_inputs: assert property (disable iff (1'b0)
    !aresetn |=> pin_oe == 8'h00 && periph_in[3:0] == 4'h0)
    else $error("Pins not inputs after reset");
  a_low_no_pull: assert property (
    (pin_oe & ~pin_out & pin_pullup) == 8'h00)
    else $error("Pull-up on a pin driven low");
  a_periph_drive: assert property (
    ((pin_out ^ $past(periph_out)) & pin_oe & $past(periph_oe)) == 8'h00)
    else $error("Peripheral output not on pin");
  a_analog_block: assert property (
    (periph_in[3:0] & analog_enable) == 4'h0)
    else $error("Digital input live on analog pin");
endmodule // gpp_port_assertions
bind gpp_port gpp_port_assertions chk (.*);
`default_nettype wire

/* File: tb/gpp_port_bench.sv */
// Self-checking bench for the eight-pin port
`timescale 1ns/100ps
`default_nettype none
`include "gpp_defines.vh"
module gpp_port_bench;
  logic        aclk = 1'b0, aresetn = 1'b0, rmw_read = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [7:0]  periph_oe = 8'h00, periph_out = 8'h00;
  logic [7:0]  ext_en = 8'h0f, ext_val = 8'h3c;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
  logic [31:0] s_axi_rdata, rd_val;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, periph_in;
  logic [3:0]  analog_enable;
  integer      err_total = 0, check_count = 0;
  gpp_port dut (.*);
  gpp_pins_model board (.*);
  always #10 aclk = ~aclk;
  // ==================
  // Shared tasks
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task hang;
    err_total++;
    $display("MISMATCH t=%0t bus timeout", $time);
    summarize;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    integer n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 40);
    if (!s_axi_bvalid) hang;
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rc(input logic [11:0] a, input logic rmw, input logic [31:0] e);
    integer n;
    @(posedge aclk);
    s_axi_araddr <= a;
    rmw_read <= rmw;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 40);
    if (!s_axi_rvalid) hang;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
  endtask
  // Pins follow a register one cycle after the write answer
  task settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask
  // ==================
  // Scenarios
  task t_reset;
    settle;
    chk(pin_oe, 8'h00);
    chk(periph_in[3:0], 4'h0);
    // Reset leaves dir 0, disable 0, pull-up 0, peripherals off
    chk(analog_enable, 4'hf);
    chk(pin_pullup, 8'h00);
    rc(`GPP_OFS_DIR, 1'b0, 32'h0000_0000);
    rc(`GPP_OFS_AIDIS, 1'b0, 32'h0000_0000);
    $display("reset test done");
  endtask
  task t_analog;
    wr(`GPP_OFS_AIDIS, 32'h0000_000f);
    settle;
    chk(periph_in[3:0], 4'hc);
    chk(analog_enable, 4'h0);
    $display("analog test done");
  endtask
  task t_output;
    wr(`GPP_OFS_DIR, 32'h0000_00f0);
    wr(`GPP_OFS_LATCH, 32'h0000_00a5);
    settle;
    chk(pin_oe, 8'hf0);
    chk(pin_out & pin_oe, 8'ha0);
    rc(`GPP_OFS_LATCH, 1'b0, 32'h0000_00ac);
    rc(`GPP_OFS_LATCH, 1'b1, 32'h0000_00a5);
    $display("output test done");
  endtask
  task t_periph;
    @(posedge aclk);
    periph_oe <= 8'h40;
    periph_out <= 8'h40;
    settle;
    chk({pin_oe[6], pin_out[6]}, 2'b11);
    rc(`GPP_OFS_LATCH, 1'b0, 32'h0000_00ec);
    rc(`GPP_OFS_LATCH, 1'b1, 32'h0000_00a5);
    @(posedge aclk);
    periph_oe <= 8'h00;
    $display("peripheral test done");
  endtask
  task t_pullup;
    wr(`GPP_OFS_PULLUP, 32'h0000_00ff);
    settle;
    chk(pin_pullup, 8'haf);
    $display("pull-up test done");
  endtask
  task t_standby;
    @(posedge aclk);
    ext_en <= 8'hff;
    ext_val <= 8'ha3;
    wr(`GPP_OFS_STBY, 32'h0000_0002);
    settle;
    chk(pin_oe, 8'hf0);
    wr(`GPP_OFS_STBY, 32'h0000_0003);
    settle;
    chk({pin_oe, periph_in}, 16'h0000);
    wr(`GPP_OFS_WAKE, 32'h0000_0003);
    settle;
    chk(periph_in, 8'ha0);
    wr(`GPP_OFS_STBY, 32'h0000_0005);
    wr(`GPP_OFS_WAKE, 32'h0000_0001);
    settle;
    chk({pin_oe, periph_in}, 16'h0000);
    wr(`GPP_OFS_STBY, 32'h0000_0000);
    settle;
    chk(pin_oe & pin_out, 8'ha0);
    $display("standby test done");
  endtask
  task t_unmapped;
    wr(12'h020, 32'h0000_0000);
    chk(wr_resp, `GPP_RESP_SLVERR);
    rc(12'h020, 1'b0, 32'h0000_0000);
    chk(rd_resp, `GPP_RESP_SLVERR);
    rc(`GPP_OFS_DIR, 1'b0, 32'h0000_00f0);
    $display("unmapped test done");
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_analog;
    t_output;
    t_periph;
    t_pullup;
    t_standby;
    t_unmapped;
    summarize;
  end
endmodule // gpp_port_bench
`default_nettype wire
